/* File: rtl/adc_sequencer_control.sv */
// Converter sequencer control with register bus slave
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module adc_sequencer_control #(
   parameter int DEPTH     = 8,
   parameter bit HIGH_GAIN = 1'b1,
   parameter int TICK_DIV  = 4
) (
   // Clock and reset
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   // Register bus write
   input  wire logic [adc_seq_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                     awvalid,
   output logic                          awready,
   input  wire logic [31:0]              wdata,
   input  wire logic [3:0]               wstrb,
   input  wire logic                     wvalid,
   output logic                          wready,
   output logic [1:0]                    bresp,
   output logic                          bvalid,
   input  wire logic                     bready,
   // Register bus read
   input  wire logic [adc_seq_pkg::ADDR_W-1:0] araddr,
   input  wire logic                     arvalid,
   output logic                          arready,
   output logic [31:0]                   rdata,
   output logic [1:0]                    rresp,
   output logic                          rvalid,
   input  wire logic                     rready,
   // Converter core
   output logic                          adc_power_on,
   output logic                          adc_clk_en,
   output logic                          conv_start,
   output logic                          conv_abort,
   output logic [adc_seq_pkg::CHAN_W-1:0] conv_chan,
   output logic                          conv_gain,
   input  wire logic                     conv_done,
   input  wire logic [adc_seq_pkg::RES_W-1:0] conv_data,
   // Interrupt
   output logic                          irq
);

   localparam int IW = $clog2(DEPTH);
   localparam int EW = adc_seq_pkg::ENT_W;

   if (DEPTH < 2 || (1 << IW) != DEPTH) begin : g_chk
      $error("adc_sequencer_control: DEPTH must be a power of two");
   end

   typedef struct packed {
      adc_seq_pkg::seq_state_e      st;
      logic [DEPTH-1:0][EW-1:0]     q;
      logic [IW:0]                  cnt;
      logic [IW-1:0]                idx;
      logic                         launched;
      logic                         stop_pend;
      logic [adc_seq_pkg::DELAY_W-1:0] dly_cnt;
      logic [adc_seq_pkg::STOP_CW-1:0] stop_cnt;
      logic                         pwr;
      logic                         circ;
      logic                         rjust;
      logic                         enh;
      logic [2:0]                   ien;
      logic [adc_seq_pkg::DELAY_W-1:0] dly;
      logic                         f_conv;
      logic                         f_seq;
      logic [adc_seq_pkg::RES_W-1:0] res;
      logic                         conv_start;
      logic                         conv_abort;
      logic                         aw_got;
      logic                         w_got;
      logic [adc_seq_pkg::ADDR_W-1:0] awaddr;
      logic [31:0]                  wdata;
      logic [3:0]                   wstrb;
      logic                         bvalid;
      logic [1:0]                   bresp;
      logic                         rvalid;
      logic [1:0]                   rresp;
      logic [31:0]                  rdata;
   } ctl_s;

   ctl_s        s_q;
   ctl_s        s_d;
   logic        tick;
   logic        wr_go;
   logic [31:0] wmask;
   logic [31:0] wv;
   logic        start_cmd;
   logic        stop_cmd;
   logic        abort_cmd;
   logic        qclr_cmd;
   logic        push_cmd;
   logic        full;
   logic        busy;
   logic [15:0] res16;
   logic [2:0]  flags;

   ////////////////////////////////////////////////////////////////////////
   // Converter clock enable
   adc_tick_gen #(
      .DIV (TICK_DIV)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Write decode; commands only act on bytes that were strobed
   assign wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
   assign wmask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}},
                   {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
   assign wv    = s_q.wdata & wmask;
   assign start_cmd = wr_go && s_q.awaddr == adc_seq_pkg::OFF_CTRL
                      && wv[adc_seq_pkg::CTRL_START];
   assign stop_cmd  = wr_go && s_q.awaddr == adc_seq_pkg::OFF_CTRL
                      && wv[adc_seq_pkg::CTRL_STOP];
   assign abort_cmd = wr_go && s_q.awaddr == adc_seq_pkg::OFF_CTRL
                      && wv[adc_seq_pkg::CTRL_ABORT];
   assign qclr_cmd  = wr_go && s_q.awaddr == adc_seq_pkg::OFF_CTRL
                      && wv[adc_seq_pkg::CTRL_QCLR];
   assign push_cmd  = wr_go && s_q.awaddr == adc_seq_pkg::OFF_QUEUE
                      && s_q.wstrb[0];
   assign full  = s_q.cnt == (IW+1)'(DEPTH);
   assign busy  = s_q.st != adc_seq_pkg::SEQ_IDLE;
   assign flags = {full, s_q.f_seq, s_q.f_conv};

   // Alignment is applied at read time so a format change is seen at once
   always_comb begin
      if (s_q.rjust) begin
         res16 = {{adc_seq_pkg::RES_PAD{1'b0}}, s_q.res};
      end else begin
         res16 = {s_q.res, {adc_seq_pkg::RES_PAD{1'b0}}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state: bus slave, registers, queue, sequencer
   always_comb begin
      s_d = s_q;
      s_d.conv_start = 1'b0;
      s_d.conv_abort = 1'b0;

      // Address and data are latched independently, in either order
      if (awvalid && awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = awaddr;
      end
      if (wvalid && wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = wdata;
         s_d.wstrb = wstrb;
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = adc_seq_pkg::RESP_OKAY;
         unique case (s_q.awaddr)
            adc_seq_pkg::OFF_CTRL: begin
               if (s_q.wstrb[0]) begin
                  s_d.pwr   = s_q.wdata[adc_seq_pkg::CTRL_PWR];
                  s_d.circ  = s_q.wdata[adc_seq_pkg::CTRL_CIRC];
                  s_d.rjust = s_q.wdata[adc_seq_pkg::CTRL_RJUST];
                  s_d.enh   = s_q.wdata[adc_seq_pkg::CTRL_ENH];
               end
            end
            adc_seq_pkg::OFF_IRQ_EN: begin
               if (s_q.wstrb[0]) begin
                  s_d.ien = s_q.wdata[2:0];
               end
            end
            adc_seq_pkg::OFF_DELAY: begin
               if (s_q.wstrb[0]) begin
                  s_d.dly = s_q.wdata[adc_seq_pkg::DELAY_W-1:0];
               end
            end
            adc_seq_pkg::OFF_FLAGS: begin
               if (wv[adc_seq_pkg::FLAG_WCONV]) begin
                  s_d.f_conv = s_q.wdata[adc_seq_pkg::FLAG_CONV];
               end
               if (wv[adc_seq_pkg::FLAG_WSEQ]) begin
                  s_d.f_seq = s_q.wdata[adc_seq_pkg::FLAG_SEQ];
               end
            end
            adc_seq_pkg::OFF_QUEUE, adc_seq_pkg::OFF_RESULT,
            adc_seq_pkg::OFF_STATE: begin
            end
            default: s_d.bresp = adc_seq_pkg::RESP_SLVERR;
         endcase
      end

      // Read: one word per request, answered at the next edge
      if (arvalid && arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = adc_seq_pkg::RESP_OKAY;
         s_d.rdata  = '0;
         unique case (araddr)
            adc_seq_pkg::OFF_CTRL:
               s_d.rdata[3:0] = {s_q.enh, s_q.rjust, s_q.circ, s_q.pwr};
            adc_seq_pkg::OFF_IRQ_EN: s_d.rdata[2:0] = s_q.ien;
            adc_seq_pkg::OFF_DELAY:
               s_d.rdata[adc_seq_pkg::DELAY_W-1:0] = s_q.dly;
            adc_seq_pkg::OFF_QUEUE: s_d.rdata[IW:0] = s_q.cnt;
            adc_seq_pkg::OFF_FLAGS: s_d.rdata[2:0] = flags;
            adc_seq_pkg::OFF_RESULT: s_d.rdata[15:0] = res16;
            adc_seq_pkg::OFF_STATE:
               s_d.rdata[IW+7:0] = {s_q.idx, 3'h0, s_q.st,
                                    s_q.stop_pend, s_q.launched, busy};
            default: s_d.rresp = adc_seq_pkg::RESP_SLVERR;
         endcase
      end else if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end

      // Queue is only edited while idle; a push when full is dropped
      if (push_cmd && !busy && !full) begin
         s_d.q[s_q.cnt[IW-1:0]] = {HIGH_GAIN &&
            s_q.wdata[adc_seq_pkg::ENT_GAIN],
            s_q.wdata[adc_seq_pkg::CHAN_W-1:0]};
         s_d.cnt = s_q.cnt + (IW+1)'(1);
      end
      if (qclr_cmd && !busy) begin
         s_d.cnt = '0;
         s_d.idx = '0;
      end

      // Sequencer
      unique case (s_q.st)
         adc_seq_pkg::SEQ_IDLE: begin
            if (start_cmd && s_q.pwr && s_q.cnt != '0) begin
               s_d.idx       = '0;
               s_d.stop_pend = 1'b0;
               s_d.launched  = 1'b0;
               if (s_q.dly == '0) begin
                  s_d.st = adc_seq_pkg::SEQ_CONV;
               end else begin
                  s_d.dly_cnt = s_q.dly;
                  s_d.st      = adc_seq_pkg::SEQ_DELAY;
               end
            end
         end
         adc_seq_pkg::SEQ_DELAY: begin
            if (s_q.dly_cnt == adc_seq_pkg::DELAY_W'(1)) begin
               s_d.st = adc_seq_pkg::SEQ_CONV;
            end else begin
               s_d.dly_cnt = s_q.dly_cnt - adc_seq_pkg::DELAY_W'(1);
            end
         end
         adc_seq_pkg::SEQ_CONV: begin
            // Launches follow a converter clock enable by one cycle
            if (!s_q.launched && tick) begin
               s_d.conv_start = 1'b1;
               s_d.launched   = 1'b1;
            end else if (s_q.launched && conv_done) begin
               s_d.res      = conv_data;
               s_d.f_conv   = 1'b1;
               s_d.launched = 1'b0;
               if ({1'b0, s_q.idx} == s_q.cnt - (IW+1)'(1)) begin
                  s_d.f_seq = 1'b1;
                  s_d.idx   = '0;
                  if (!s_q.circ) begin
                     s_d.st = adc_seq_pkg::SEQ_IDLE;
                  end
               end else begin
                  s_d.idx = s_q.idx + IW'(1);
               end
               if (s_q.stop_pend) begin
                  s_d.st       = adc_seq_pkg::SEQ_STOP;
                  s_d.stop_cnt = '0;
                  s_d.stop_pend = 1'b0;
               end
            end
         end
         adc_seq_pkg::SEQ_STOP: begin
            // Stop completion is counted in converter clock enables
            if (tick) begin
               if (s_q.stop_cnt ==
                   adc_seq_pkg::STOP_CW'(adc_seq_pkg::STOP_TICKS - 1)) begin
                  s_d.st  = adc_seq_pkg::SEQ_IDLE;
                  s_d.idx = '0;
               end else begin
                  s_d.stop_cnt = s_q.stop_cnt + adc_seq_pkg::STOP_CW'(1);
               end
            end
         end
      endcase

      // Abort, power loss and a stop not deferred by enhanced mode override the step above
      if ((abort_cmd || !s_q.pwr || (stop_cmd &&
           !(s_q.enh && s_q.launched && !conv_done)))
          && (s_q.st == adc_seq_pkg::SEQ_DELAY
              || s_q.st == adc_seq_pkg::SEQ_CONV)) begin
         s_d.st         = adc_seq_pkg::SEQ_STOP;
         s_d.stop_cnt   = '0;
         s_d.conv_abort = s_q.launched && !conv_done;
         s_d.conv_start = 1'b0;
         s_d.launched   = 1'b0;
         s_d.stop_pend  = 1'b0;
      end else if (stop_cmd && s_q.enh && s_q.launched && !conv_done
                   && s_q.st == adc_seq_pkg::SEQ_CONV) begin
         s_d.stop_pend = 1'b1;
      end else if (stop_cmd && s_q.st == adc_seq_pkg::SEQ_IDLE) begin
         s_d.idx = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; reset powers down and clears enables and flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q         <= '0;
         s_q.ien     <= adc_seq_pkg::IEN_RST;
         s_q.dly     <= adc_seq_pkg::DELAY_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign awready      = !s_q.aw_got && !s_q.bvalid;
   assign wready       = !s_q.w_got && !s_q.bvalid;
   assign bvalid       = s_q.bvalid;
   assign bresp        = s_q.bresp;
   assign arready      = !s_q.rvalid;
   assign rvalid       = s_q.rvalid;
   assign rresp        = s_q.rresp;
   assign rdata        = s_q.rdata;
   assign adc_power_on = s_q.pwr;
   assign adc_clk_en   = tick;
   assign conv_start   = s_q.conv_start;
   assign conv_abort   = s_q.conv_abort;
   assign conv_chan    = s_q.q[s_q.idx][adc_seq_pkg::CHAN_W-1:0];
   assign conv_gain    = s_q.q[s_q.idx][adc_seq_pkg::ENT_GAIN];
   assign irq          = |(flags & s_q.ien);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [adc_seq_pkg::STOP_CW:0] stop_ticks_h;

   // Counts converter enables seen in the stop state
   always_ff @(posedge aclk) begin
      if (!aresetn || s_q.st != adc_seq_pkg::SEQ_STOP) begin
         stop_ticks_h <= '0;
      end else if (tick) begin
         stop_ticks_h <= stop_ticks_h + (adc_seq_pkg::STOP_CW+1)'(1);
      end
   end

   a_reset_state: assert property (@(posedge aclk)
      !aresetn |=> (!adc_power_on && s_q.ien == '0 && s_q.dly == '0
                    && flags[1:0] == '0 && !busy))
      else $error("reset state wrong");

   a_start_refused: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (!busy && start_cmd && (!s_q.pwr || s_q.cnt == '0)) |=> !busy)
      else $error("start taken while refused");

   a_delay_loaded: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (!busy ##1 s_q.st == adc_seq_pkg::SEQ_DELAY)
      |-> s_q.dly_cnt == $past(s_q.dly) && $past(start_cmd))
      else $error("delay not loaded from start");

   a_no_redelay: assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_q.st == adc_seq_pkg::SEQ_CONV
      |=> s_q.st != adc_seq_pkg::SEQ_DELAY)
      else $error("delay repeated inside sequence");

   a_stop_length: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (s_q.st == adc_seq_pkg::SEQ_STOP ##1 !busy)
      |-> $past(stop_ticks_h) == adc_seq_pkg::STOP_TICKS - 1)
      else $error("stop length wrong");

   a_enh_defer: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (stop_cmd && !abort_cmd && s_q.pwr && s_q.enh && s_q.launched
       && !conv_done && s_q.st == adc_seq_pkg::SEQ_CONV)
      |=> !conv_abort && s_q.st == adc_seq_pkg::SEQ_CONV && s_q.stop_pend)
      else $error("stop not deferred");

   a_result_format: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (arvalid && arready && araddr == adc_seq_pkg::OFF_RESULT)
      |=> rvalid && rdata[15:0] == ($past(s_q.rjust)
          ? {6'h00, $past(s_q.res)} : {$past(s_q.res), 6'h00}))
      else $error("result alignment wrong");

   a_conv_flag: assert property (@(posedge aclk)
      disable iff (!aresetn)
      (s_q.st == adc_seq_pkg::SEQ_CONV && s_q.launched && conv_done)
      |=> s_q.f_conv && s_q.res == $past(conv_data))
      else $error("conversion flag not set");

   a_gain_lock: assert property (@(posedge aclk)
      disable iff (!aresetn)
      !HIGH_GAIN |-> !conv_gain)
      else $error("high gain on low gain variant");

endmodule // adc_sequencer_control

/* File: rtl/adc_seq_pkg.sv */
// Constants shared by the converter sequencer control files
package adc_seq_pkg;

   // Register byte offsets on the register bus
   localparam int          ADDR_W     = 5;
   localparam logic [4:0]  OFF_CTRL   = 5'h00;
   localparam logic [4:0]  OFF_IRQ_EN = 5'h04;
   localparam logic [4:0]  OFF_DELAY  = 5'h08;
   localparam logic [4:0]  OFF_QUEUE  = 5'h0C;
   localparam logic [4:0]  OFF_FLAGS  = 5'h10;
   localparam logic [4:0]  OFF_RESULT = 5'h14;
   localparam logic [4:0]  OFF_STATE  = 5'h18;

   // Control register bits
   localparam int CTRL_PWR   = 0;
   localparam int CTRL_CIRC  = 1;
   localparam int CTRL_RJUST = 2;
   localparam int CTRL_ENH   = 3;
   localparam int CTRL_START = 8;
   localparam int CTRL_STOP  = 9;
   localparam int CTRL_ABORT = 10;
   localparam int CTRL_QCLR  = 11;

   // Event flag bits and their write-select bits
   localparam int FLAG_CONV  = 0;
   localparam int FLAG_SEQ   = 1;
   localparam int FLAG_FULL  = 2;
   localparam int FLAG_WCONV = 8;
   localparam int FLAG_WSEQ  = 9;

   // Queue entry layout
   localparam int CHAN_W     = 3;
   localparam int ENT_GAIN   = 3;
   localparam int ENT_W      = 4;

   // Widths and timing
   localparam int RES_W      = 10;
   localparam int DELAY_W    = 8;
   localparam int STOP_TICKS = 20;
   localparam int STOP_CW    = 5;
   localparam int RES_PAD    = 6;

   // Reset values
   localparam logic [DELAY_W-1:0] DELAY_RST = 8'h00;
   localparam logic [2:0]         IEN_RST   = 3'h0;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_DELAY,
      SEQ_CONV,
      SEQ_STOP
   } seq_state_e;

endpackage

/* File: rtl/adc_tick_gen.sv */
// Converter clock enable divider on the main clock
`timescale 1ns/1ps
module adc_tick_gen #(
   parameter int DIV = 4
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Converter clock enable pulse
   output logic      tick
);

   localparam int CW = $clog2(DIV);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } div_s;

   div_s s_q;
   div_s s_d;

   // A divide of one would leave no idle edge between ticks
   if (DIV < 2) begin : g_chk
      $error("adc_tick_gen: DIV must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////
   // Free-running count, one pulse per DIV cycles
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == CW'(DIV - 1)) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule // adc_tick_gen

/* File: sim/testbench.sv */
// Self-checking bench for the converter sequencer control
`timescale 1ns/1ps
module testbench;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rd;
   logic [3:0]  wstrb;
   logic [9:0]  conv_data;
   logic        conv_done = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, adc_power_on;
   logic        adc_clk_en, conv_start, conv_abort, conv_gain, first_gain;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [2:0]  conv_chan, first_chan;
   int          errors = 0, checks_done = 0, n_conv = 0, dcnt = 0, i;
   int          cyc = 0, t_first = 0, t_last = 0, n_abort = 0, n_tick = 0;
   localparam int WAKE_CYC = 1200; // 30 us of 25 ns cycles

   adc_sequencer_control #(.DEPTH(8), .HIGH_GAIN(1'b1), .TICK_DIV(2))
      adc_sequencer_control_i (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .adc_power_on(adc_power_on), .adc_clk_en(adc_clk_en),
      .conv_start(conv_start), .conv_abort(conv_abort),
      .conv_chan(conv_chan), .conv_gain(conv_gain), .conv_done(conv_done),
      .conv_data(conv_data), .irq(irq));

   // Clock at 40 MHz
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter stand-in: fixed result three cycles after each start
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      conv_done <= (dcnt == 1) && !conv_abort;
      if (adc_clk_en) n_tick <= n_tick + 1;
      if (conv_abort) n_abort <= n_abort + 1;
      if (dcnt > 0) dcnt <= dcnt - 1;
      if (conv_start) begin
         dcnt <= 3;
         if (n_conv == 0) begin
            first_chan <= conv_chan;
            first_gain <= conv_gain;
         end
      end
      if (conv_abort) dcnt <= 0;
      if (conv_done) begin
         if (n_conv == 0) t_first <= cyc;
         t_last <= cyc;
         n_conv <= n_conv + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // A used-up wait counts as a mismatch and ends the run
   task automatic tmo(input int n);
      if (n >= 200) begin
         errors++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
         stop_test();
      end
   endtask

   // Write and read cycles; each channel released when taken
   // Handshakes judged on values settled before the edge; bready stays up
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      logic aw_t, w_t, b_t;
      logic [1:0] resp;
      awaddr <= a; wdata <= d; wstrb <= 4'hF;
      awvalid <= 1'b1; wvalid <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(negedge aclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) break;
      end
      tmo(n);
      chk({30'h0, resp}, {30'h0, adc_seq_pkg::RESP_OKAY});
   endtask

   task automatic rdr(input logic [4:0] a,
                      input logic [1:0] er = adc_seq_pkg::RESP_OKAY);
      int n;
      logic ar_t, r_t;
      logic [1:0] resp;
      araddr <= a; arvalid <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(negedge aclk);
         ar_t = arvalid && arready;
         r_t = rvalid;
         rd = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ar_t) arvalid <= 1'b0;
         if (r_t) break;
      end
      tmo(n);
      chk({30'h0, resp}, {30'h0, er});
   endtask

   // Returns at the edge that ends a conv_start pulse
   task automatic wait_launch();
      int n;
      for (n = 0; n < 200; n++) begin
         @(negedge aclk);
         if (conv_start) break;
      end
      tmo(n);
      @(posedge aclk);
   endtask

   task automatic poll(input logic [4:0] a, input logic [31:0] m, v);
      int n;
      for (n = 0; n < 200; n++) begin
         rdr(a);
         if ((rd & m) === v) break;
      end
      tmo(n);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1;
      arvalid = 1'b0; rready = 1'b1; awaddr = '0; araddr = '0;
      wdata = '0; wstrb = '0; conv_data = 10'h2A5;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, power state and an unmapped place
      rdr(adc_seq_pkg::OFF_CTRL); chk(rd, 32'h0);
      rdr(adc_seq_pkg::OFF_IRQ_EN); chk(rd, 32'h0);
      rdr(adc_seq_pkg::OFF_DELAY); chk(rd, 32'h0);
      rdr(adc_seq_pkg::OFF_FLAGS); chk(rd, 32'h0);
      chk({31'h0, adc_power_on}, 32'h0);
      rdr(5'h1C, adc_seq_pkg::RESP_SLVERR); chk(rd, 32'h0);
      // Converter clock enable: one pulse every two main clocks
      i = n_tick;
      repeat (20) @(posedge aclk);
      chk(32'(n_tick - i), 32'd10);
      $display("test reset done");
      // Fill the queue, then start while still powered down
      for (i = 0; i < 8; i++) wr(adc_seq_pkg::OFF_QUEUE, {28'h0, i[0], 3'(7 - i)});
      rdr(adc_seq_pkg::OFF_FLAGS); chk(rd, 32'h4);
      wr(adc_seq_pkg::OFF_CTRL, 32'h100);
      rdr(adc_seq_pkg::OFF_STATE); chk(rd & 32'h1, 32'h0);
      $display("test start refused done");
      // Sequence run with longest start delay
      wr(adc_seq_pkg::OFF_IRQ_EN, 32'h3);
      wr(adc_seq_pkg::OFF_DELAY, 32'hFF);
      // Power up first, then settle before any start
      wr(adc_seq_pkg::OFF_CTRL, 32'h1);
      repeat (WAKE_CYC) @(posedge aclk);
      wr(adc_seq_pkg::OFF_CTRL, 32'h101);
      rdr(adc_seq_pkg::OFF_STATE); chk(rd & 32'h18, 32'h08);
      poll(adc_seq_pkg::OFF_FLAGS, 32'h2, 32'h2);
      chk(32'(n_conv), 32'd8);
      chk({28'h0, first_chan, first_gain}, 32'hE);
      chk(32'(t_last - t_first < 100), 32'h1);
      rdr(adc_seq_pkg::OFF_FLAGS); chk(rd, 32'h7);
      chk({31'h0, irq}, 32'h1);
      rdr(adc_seq_pkg::OFF_STATE); chk(rd & 32'h1, 32'h0);
      rdr(adc_seq_pkg::OFF_RESULT); chk(rd, 32'hA940);
      wr(adc_seq_pkg::OFF_CTRL, 32'h5);
      rdr(adc_seq_pkg::OFF_RESULT); chk(rd, 32'h2A5);
      $display("test sequence done");
      // Flags cleared together, then one set alone; enables act separately
      wr(adc_seq_pkg::OFF_FLAGS, 32'h300);
      rdr(adc_seq_pkg::OFF_FLAGS); chk(rd, 32'h4);
      chk({31'h0, irq}, 32'h0);
      wr(adc_seq_pkg::OFF_FLAGS, 32'h202);
      rdr(adc_seq_pkg::OFF_FLAGS); chk(rd, 32'h6);
      wr(adc_seq_pkg::OFF_IRQ_EN, 32'h4);
      rdr(adc_seq_pkg::OFF_FLAGS); chk({31'h0, irq}, 32'h1);
      $display("test flags done");
      // Circular run, then stopped mid-way
      wr(adc_seq_pkg::OFF_DELAY, 32'h0);
      wr(adc_seq_pkg::OFF_CTRL, 32'h103);
      for (i = 0; i < 200 && n_conv < 20; i++) @(posedge aclk);
      tmo(i);
      rdr(adc_seq_pkg::OFF_STATE); chk(rd & 32'h1, 32'h1);
      wr(adc_seq_pkg::OFF_CTRL, 32'h203);
      rdr(adc_seq_pkg::OFF_STATE); chk(rd & 32'h18, 32'h18);
      poll(adc_seq_pkg::OFF_STATE, 32'h1, 32'h0);
      chk(rd & 32'h1F, 32'h0);
      $display("test circular stop done");
      // Enhanced stop during a conversion waits for its result
      i = n_abort;
      wr(adc_seq_pkg::OFF_CTRL, 32'h10B);
      wait_launch();
      wr(adc_seq_pkg::OFF_CTRL, 32'h20B);
      rdr(adc_seq_pkg::OFF_STATE); chk(rd & 32'h1C, 32'h14);
      poll(adc_seq_pkg::OFF_STATE, 32'h1, 32'h0);
      chk(32'(n_abort - i), 32'h0);
      // Abort kills the running conversion, then power-down
      wr(adc_seq_pkg::OFF_CTRL, 32'h10B);
      wait_launch();
      wr(adc_seq_pkg::OFF_CTRL, 32'h40B);
      poll(adc_seq_pkg::OFF_STATE, 32'h1, 32'h0);
      chk(32'(n_abort - i), 32'h1);
      wr(adc_seq_pkg::OFF_CTRL, 32'h0);
      chk({31'h0, adc_power_on}, 32'h0);
      $display("test abort and power-down done");
      stop_test();
   end
endmodule // testbench
